// ==== rtl/fbid_regs.vh ====
`ifndef FBID_REGS_VH
`define FBID_REGS_VH

// Register byte offsets
`define FBID_REG_SEL 5'h00
`define FBID_REG_CTRL 5'h04
`define FBID_REG_ADDR 5'h08
`define FBID_REG_STAT 5'h0C
`define FBID_REG_DIAG 5'h10

// Identification selector codes
`define FBID_SEL_PROFILE 8'h00
`define FBID_SEL_NEW 8'h01
`define FBID_SEL_AUTO 8'h7F
`define FBID_SEL_LEGACY 8'h80
`define FBID_SEL_RST 8'h00

// Station addressing
`define FBID_ADDR_MAX 7'h7D
`define FBID_ADDR_FACTORY 7'h7E

// Block and module counts per identity
`define FBID_BLOCKS 4'h3
`define FBID_MODULES 2'h1

// Control register fields
`define FBID_CTRL_FMT_BIT 0

// Status register fields
`define FBID_STAT_DEF_BIT 16
`define FBID_STAT_CYC_BIT 17
`define FBID_STAT_HW_BIT 18
`define FBID_STAT_PEND_BIT 19
`define FBID_STAT_ADDR_LSB 20

// Address settle time
`define FBID_SETTLE_S 32'h0000_000A
`define FBID_CLK_HZ 32'h0BEB_C200
`define FBID_SETTLE_CYCLES (`FBID_SETTLE_S * `FBID_CLK_HZ)

`endif

// ==== rtl/fbid_sync.v ====
`timescale 1ns/10ps
module fbid_sync #(
  parameter W = 8
) (
  input wire ref_clk,
  input wire nrst,
  input wire [W-1:0] pin_in,
  output wire [W-1:0] sync_out
);
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1)
    begin : g_bit
      reg meta_r;
      reg sync_r;
      // One process per bit keeps each flop with a single driver
      always @(posedge ref_clk or negedge nrst)
      begin
        if (!nrst)
        begin
          meta_r <= 1'b0;
          sync_r <= 1'b0;
        end
        else
        begin
          meta_r <= pin_in[i];
          sync_r <= meta_r;
        end
      end
      assign sync_out[i] = sync_r;
    end
  endgenerate
endmodule

// ==== rtl/fbid_settle.v ====
`timescale 1ns/10ps
module fbid_settle #(
  parameter [31:0] CYCLES = 32'h0000_0010
) (
  input wire ref_clk,
  input wire nrst,
  input wire start,
  output reg busy_r,
  output reg done_r
);
  reg [31:0] cnt_r;
  // Each new start rearms the full wait, so a switch being turned restarts it
  always @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cnt_r <= 32'h0000_0000;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end
    else
    begin
      done_r <= 1'b0;
      if (start)
      begin
        cnt_r <= CYCLES - 32'h0000_0001;
        busy_r <= 1'b1;
      end
      else if (busy_r)
      begin
        if (cnt_r == 32'h0000_0000)
        begin
          busy_r <= 1'b0;
          done_r <= 1'b1;
        end
        else
          cnt_r <= cnt_r - 32'h0000_0001;
      end
    end
  end
endmodule

// ==== rtl/fbid_core.v ====
// Contract
// - Selector 0 profile,1 new,127 auto,128 legacy
// - Selector changes only without cyclic exchange
// - Identity held while cyclic exchange runs
// - Re-established exchange resumes last identity
// - Legacy identity: classic status, old diagnostics
// - Profile/new: new diagnostics, configurable status format
// - Selector 0/1: three blocks, one module
// - Cyclic access only to configured modules
// - Auto mode takes identity from frames
// - Frame identity change: auto mode, known only
// - Unfixed auto mode rotates identity per diagnose
// - Fixed auto identity behaves like static; code still adopts known frame identities when fixed
// - Valid station addresses are 0 to 125
// - Factory: address 126, software addressing
// - Address from class 2 master or switches
// - Hardware address from seven weighted switches
// - Switch change: wait 10 s, restart, adopt
// - Selector writes during cyclic exchange ignored
`timescale 1ns/10ps
`include "fbid_regs.vh"
module fbid_core #(
  parameter [31:0] SETTLE_CYCLES = `FBID_SETTLE_CYCLES,
  parameter [15:0] PROFILE_ID = 16'h0A01, // Arbitrary identity value
  parameter [15:0] NEW_ID = 16'h0A02, // Arbitrary identity value
  parameter [15:0] LEGACY_ID = 16'h0A03, // Arbitrary identity value
  parameter [1:0] LEGACY_MODULES = 2'h1
) (
  input wire ref_clk,
  input wire nrst,
  input wire [4:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  input wire cyclic_active,
  input wire user_cfg_condensed,
  input wire prm_frame_pulse,
  input wire addr_frame_pulse,
  input wire [15:0] frame_ident,
  input wire [6:0] frame_new_addr,
  input wire diag_req_pulse,
  input wire cyc_access_req,
  input wire [1:0] cyc_module_idx,
  input wire [7:0] dip_pins,
  output reg [15:0] active_ident_r,
  output reg ident_defined_r,
  output reg status_condensed_r,
  output reg new_diag_r,
  output reg [15:0] diag_ident_r,
  output reg diag_valid_r,
  output reg [1:0] module_count_r,
  output reg cyc_access_grant_r,
  output reg [6:0] station_addr_r,
  output reg restart_r
);
  // Identity tracking states
  localparam [1:0] ST_STATIC = 2'h0;
  localparam [1:0] ST_HUNT = 2'h1;
  localparam [1:0] ST_FIXED = 2'h2;

  reg [7:0] sel_r;
  reg fmt_choice_r;
  reg [6:0] soft_addr_r;
  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg [1:0] cand_idx_r;
  reg [1:0] boot_cnt_r;
  reg [7:0] dip_prev_r;
  reg [31:0] rd_mux;
  wire [7:0] dip_sync;
  wire hw_mode;
  wire [6:0] dip_addr;
  wire bus_wr;
  wire sel_we;
  wire frame_id_ok;
  wire bus_addr_we;
  wire frm_addr_we;
  wire soft_addr_we;
  wire [6:0] soft_addr_val;
  wire booted;
  wire dip_change;
  wire settle_busy;
  wire settle_done;
  wire legacy_now;

  function sel_ok;
    input [7:0] v;
    begin
      sel_ok = (v == `FBID_SEL_PROFILE) || (v == `FBID_SEL_NEW) ||
               (v == `FBID_SEL_AUTO) || (v == `FBID_SEL_LEGACY);
    end
  endfunction

  function [15:0] ident_of_sel;
    input [7:0] v;
    begin
      case (v)
        `FBID_SEL_NEW: ident_of_sel = NEW_ID;
        `FBID_SEL_LEGACY: ident_of_sel = LEGACY_ID;
        default: ident_of_sel = PROFILE_ID;
      endcase
    end
  endfunction

  function [15:0] ident_of_cand;
    input [1:0] idx;
    begin
      case (idx)
        2'h0: ident_of_cand = PROFILE_ID;
        2'h1: ident_of_cand = LEGACY_ID;
        default: ident_of_cand = NEW_ID;
      endcase
    end
  endfunction

  function ident_known;
    input [15:0] id;
    begin
      ident_known = (id == PROFILE_ID) || (id == NEW_ID) || (id == LEGACY_ID);
    end
  endfunction

  function addr_ok;
    input [6:0] a;
    begin
      addr_ok = (a <= `FBID_ADDR_MAX);
    end
  endfunction

  fbid_sync #(
    .W(8)
  ) u_sync (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .pin_in(dip_pins),
    .sync_out(dip_sync)
  );

  fbid_settle #(
    .CYCLES(SETTLE_CYCLES)
  ) u_settle (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .start(dip_change),
    .busy_r(settle_busy),
    .done_r(settle_done)
  );

  // Switch 8 off selects hardware addressing
  assign hw_mode = ~dip_sync[7];
  assign dip_addr = dip_sync[6:0];
  assign booted = (boot_cnt_r == 2'h3);
  assign dip_change = booted && (dip_sync != dip_prev_r);
  assign bus_wr = avs_write && !avs_waitrequest;
  assign sel_we = bus_wr && (avs_address == `FBID_REG_SEL) && !cyclic_active &&
                  sel_ok(avs_writedata[7:0]);
  assign frame_id_ok = (prm_frame_pulse || addr_frame_pulse) && !cyclic_active &&
                       ident_known(frame_ident);
  // Whole word checked, so a large value cannot alias into range
  assign bus_addr_we = bus_wr && (avs_address == `FBID_REG_ADDR) &&
                       addr_ok(avs_writedata[6:0]) && (avs_writedata[31:7] == 25'h000_0000);
  assign frm_addr_we = addr_frame_pulse && !cyclic_active && addr_ok(frame_new_addr);
  assign soft_addr_we = bus_addr_we || frm_addr_we;
  assign soft_addr_val = bus_addr_we ? avs_writedata[6:0] : frame_new_addr;
  assign legacy_now = ident_defined_r && (active_ident_r == LEGACY_ID);

  // One wait cycle per access; read data captured when waitrequest drops
  always @*
  begin
    rd_mux = 32'h0000_0000;
    case (avs_address)
      `FBID_REG_SEL: rd_mux[7:0] = sel_r;
      `FBID_REG_CTRL: rd_mux[`FBID_CTRL_FMT_BIT] = fmt_choice_r;
      `FBID_REG_ADDR: rd_mux[6:0] = soft_addr_r;
      `FBID_REG_STAT:
      begin
        rd_mux[15:0] = active_ident_r;
        rd_mux[`FBID_STAT_DEF_BIT] = ident_defined_r;
        rd_mux[`FBID_STAT_CYC_BIT] = cyclic_active;
        rd_mux[`FBID_STAT_HW_BIT] = hw_mode;
        rd_mux[`FBID_STAT_PEND_BIT] = settle_busy;
        rd_mux[`FBID_STAT_ADDR_LSB+6:`FBID_STAT_ADDR_LSB] = station_addr_r;
      end
      `FBID_REG_DIAG:
      begin
        rd_mux[15:0] = diag_ident_r;
        rd_mux[19:16] = `FBID_BLOCKS;
        rd_mux[21:20] = module_count_r;
      end
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
    end
    else if ((avs_read || avs_write) && avs_waitrequest)
    begin
      avs_waitrequest <= 1'b0;
      avs_readdata <= rd_mux;
    end
    else
      avs_waitrequest <= 1'b1;
  end

  always @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sel_r <= `FBID_SEL_RST;
      fmt_choice_r <= 1'b0;
    end
    else
    begin
      if (sel_we)
        sel_r <= avs_writedata[7:0];
      if (bus_wr && (avs_address == `FBID_REG_CTRL))
        fmt_choice_r <= avs_writedata[`FBID_CTRL_FMT_BIT];
    end
  end

  always @*
  begin
    state_nxt = state_r;
    case (state_r)
      ST_STATIC:
      begin
        if (sel_we && (avs_writedata[7:0] == `FBID_SEL_AUTO))
          state_nxt = ST_HUNT;
      end
      ST_HUNT:
      begin
        if (sel_we && (avs_writedata[7:0] != `FBID_SEL_AUTO))
          state_nxt = ST_STATIC;
        else if (frame_id_ok)
          state_nxt = ST_FIXED;
      end
      ST_FIXED:
      begin
        if (sel_we)
          state_nxt = (avs_writedata[7:0] == `FBID_SEL_AUTO) ? ST_HUNT : ST_STATIC;
      end
      default: state_nxt = ST_STATIC;
    endcase
  end

  // Identity only moves while no exchange runs, so a dropped and re-made
  // exchange finds the last identity untouched
  always @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_r <= ST_STATIC;
      active_ident_r <= PROFILE_ID;
      ident_defined_r <= 1'b1;
      cand_idx_r <= 2'h0;
      diag_ident_r <= 16'h0000;
      diag_valid_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      diag_valid_r <= 1'b0;
      if (sel_we && (avs_writedata[7:0] == `FBID_SEL_AUTO))
      begin
        ident_defined_r <= 1'b0;
        cand_idx_r <= 2'h0;
      end
      else if (sel_we)
      begin
        active_ident_r <= ident_of_sel(avs_writedata[7:0]);
        ident_defined_r <= 1'b1;
      end
      else if (frame_id_ok && (state_r != ST_STATIC))
      begin
        active_ident_r <= frame_ident;
        ident_defined_r <= 1'b1;
      end
      if (diag_req_pulse)
      begin
        diag_valid_r <= 1'b1;
        if (state_r == ST_HUNT)
        begin
          diag_ident_r <= ident_of_cand(cand_idx_r);
          cand_idx_r <= (cand_idx_r == 2'h2) ? 2'h0 : cand_idx_r + 2'h1;
        end
        else
          diag_ident_r <= active_ident_r;
      end
    end
  end

  // Status, diagnostics and module map follow the identity in use
  always @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      status_condensed_r <= 1'b0;
      new_diag_r <= 1'b0;
      module_count_r <= 2'h0;
      cyc_access_grant_r <= 1'b0;
    end
    else
    begin
      status_condensed_r <= ident_defined_r && !legacy_now &&
                            (fmt_choice_r || user_cfg_condensed);
      new_diag_r <= ident_defined_r && !legacy_now;
      if (!ident_defined_r)
        module_count_r <= 2'h0;
      else if (legacy_now)
        module_count_r <= LEGACY_MODULES;
      else
        module_count_r <= `FBID_MODULES;
      cyc_access_grant_r <= cyc_access_req && cyclic_active &&
                            (cyc_module_idx < module_count_r);
    end
  end

  // Switches are read only after the synchroniser has filled
  always @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      boot_cnt_r <= 2'h0;
      dip_prev_r <= 8'h00;
      soft_addr_r <= `FBID_ADDR_FACTORY;
      station_addr_r <= `FBID_ADDR_FACTORY;
      restart_r <= 1'b0;
    end
    else
    begin
      restart_r <= 1'b0;
      if (!booted)
      begin
        boot_cnt_r <= boot_cnt_r + 2'h1;
        if (boot_cnt_r == 2'h2)
        begin
          dip_prev_r <= dip_sync;
          station_addr_r <= hw_mode ? dip_addr : soft_addr_r;
        end
      end
      else
      begin
        dip_prev_r <= dip_sync;
        if (settle_done)
        begin
          station_addr_r <= hw_mode ? dip_addr : soft_addr_r;
          restart_r <= 1'b1;
        end
        else if (soft_addr_we && !hw_mode && !settle_busy)
          station_addr_r <= soft_addr_val;
      end
      if (soft_addr_we)
        soft_addr_r <= soft_addr_val;
    end
  end
endmodule

// ==== verification/fbid_core_properties.sv ====
`timescale 1ns/10ps
module fbid_chk #(
  parameter [15:0] LEGACY_ID = 16'h0A03 // Arbitrary identity value
) (
  input wire ref_clk,
  input wire nrst,
  input wire avs_waitrequest,
  input wire cyclic_active,
  input wire diag_req_pulse,
  input wire cyc_access_req,
  input wire [1:0] cyc_module_idx,
  input wire [15:0] active_ident_r,
  input wire ident_defined_r,
  input wire new_diag_r,
  input wire diag_valid_r,
  input wire [1:0] module_count_r,
  input wire cyc_access_grant_r,
  input wire restart_r
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);
  wire leg = ident_defined_r && active_ident_r == LEGACY_ID;
  wire nleg = ident_defined_r && active_ident_r != LEGACY_ID;
  wire gok = cyc_access_req && cyclic_active && cyc_module_idx < module_count_r;
  a_wait_one: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low twice");
  a_diag_answer: assert property (diag_req_pulse |=> diag_valid_r)
    else $error("diagnose not answered");
  a_diag_spurious: assert property (!diag_req_pulse |=> !diag_valid_r)
    else $error("diagnose answer without request");
  a_ident_hold: assert property (cyclic_active |=> $stable(active_ident_r))
    else $error("identity moved in cyclic exchange");
  a_legacy_diag: assert property ($past(leg, 2) && $past(leg) && leg |-> !new_diag_r)
    else $error("legacy identity with new diagnostics");
  a_new_diag: assert property ($past(nrst) && $past(nleg, 2) && $past(nleg) && nleg
    |-> new_diag_r)
    else $error("new identity with old diagnostics");
  a_module_cnt: assert property ($past(nrst, 2) && $past(ident_defined_r) &&
    ident_defined_r |-> module_count_r == 2'h1)
    else $error("module count wrong");
  a_grant_ok: assert property (gok |=> cyc_access_grant_r)
    else $error("cyclic access not granted");
  a_grant_no: assert property (!gok |=> !cyc_access_grant_r)
    else $error("cyclic access wrongly granted");
  a_restart_one: assert property (restart_r |=> !restart_r)
    else $error("restart longer than one cycle");
endmodule

bind fbid_core fbid_chk #(.LEGACY_ID(LEGACY_ID)) i_chk (
  .ref_clk(ref_clk),
  .nrst(nrst),
  .avs_waitrequest(avs_waitrequest),
  .cyclic_active(cyclic_active),
  .diag_req_pulse(diag_req_pulse),
  .cyc_access_req(cyc_access_req),
  .cyc_module_idx(cyc_module_idx),
  .active_ident_r(active_ident_r),
  .ident_defined_r(ident_defined_r),
  .new_diag_r(new_diag_r),
  .diag_valid_r(diag_valid_r),
  .module_count_r(module_count_r),
  .cyc_access_grant_r(cyc_access_grant_r),
  .restart_r(restart_r)
);

// ==== verification/fbid_mst.sv ====
`timescale 1ns/10ps
module fbid_mst (
  input wire ref_clk,
  input wire [15:0] diag_ident_r,
  input wire diag_valid_r,
  output reg cyclic_active,
  output reg prm_frame_pulse,
  output reg addr_frame_pulse,
  output reg [15:0] frame_ident,
  output reg [6:0] frame_new_addr,
  output reg diag_req_pulse
);
  initial
  begin
    cyclic_active = 1'b0;
    prm_frame_pulse = 1'b0;
    addr_frame_pulse = 1'b0;
    frame_ident = 16'h5A5A;
    frame_new_addr = 7'h55;
    diag_req_pulse = 1'b0;
  end
  task set_cyc(input c);
  begin
    cyclic_active <= c;
    @(posedge ref_clk);
  end
  endtask
  // Fields inverted after the frame, so a stale ident is never reused
  task frame(input p, input [15:0] id, input [6:0] a);
  begin
    prm_frame_pulse <= p;
    addr_frame_pulse <= !p;
    frame_ident <= id;
    frame_new_addr <= a;
    @(posedge ref_clk);
    prm_frame_pulse <= 1'b0;
    addr_frame_pulse <= 1'b0;
    frame_ident <= ~id;
    frame_new_addr <= ~a;
  end
  endtask
  task diag(output [15:0] id, output v);
  begin
    diag_req_pulse <= 1'b1;
    @(posedge ref_clk);
    diag_req_pulse <= 1'b0;
    @(posedge ref_clk);
    id = diag_ident_r;
    v = diag_valid_r;
  end
  endtask
endmodule

// ==== verification/tb.sv ====
`timescale 1ns/10ps
`include "fbid_regs.vh"
module tb;
  localparam [15:0] PID = 16'h0A01; // Arbitrary identity value
  localparam [15:0] NID = 16'h0A02; // Arbitrary identity value
  localparam [15:0] LID = 16'h0A03; // Arbitrary identity value
  localparam [63:0] ROT = {PID, LID, NID, PID};
  reg ref_clk, nrst, avs_read, avs_write, user_cfg_condensed, cyc_access_req, v;
  reg [4:0] avs_address;
  reg [31:0] avs_writedata, q;
  reg [1:0] cyc_module_idx;
  reg [7:0] dip_pins;
  reg [15:0] id;
  wire [31:0] avs_readdata;
  wire avs_waitrequest, cyclic_active, prm_frame_pulse, addr_frame_pulse, diag_req_pulse;
  wire ident_defined_r, status_condensed_r, new_diag_r, diag_valid_r;
  wire cyc_access_grant_r, restart_r;
  wire [15:0] frame_ident, active_ident_r, diag_ident_r;
  wire [6:0] frame_new_addr, station_addr_r;
  wire [1:0] module_count_r;
  integer err_count, check_count, n, k;
  fbid_core #(.SETTLE_CYCLES(32'h0000_0014), .PROFILE_ID(PID), .NEW_ID(NID),
    .LEGACY_ID(LID)) i_dut (.ref_clk(ref_clk), .nrst(nrst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .cyclic_active(cyclic_active), .user_cfg_condensed(user_cfg_condensed),
    .prm_frame_pulse(prm_frame_pulse), .addr_frame_pulse(addr_frame_pulse),
    .frame_ident(frame_ident), .frame_new_addr(frame_new_addr),
    .diag_req_pulse(diag_req_pulse), .cyc_access_req(cyc_access_req),
    .cyc_module_idx(cyc_module_idx), .dip_pins(dip_pins), .active_ident_r(active_ident_r),
    .ident_defined_r(ident_defined_r), .status_condensed_r(status_condensed_r),
    .new_diag_r(new_diag_r), .diag_ident_r(diag_ident_r), .diag_valid_r(diag_valid_r),
    .module_count_r(module_count_r), .cyc_access_grant_r(cyc_access_grant_r),
    .station_addr_r(station_addr_r), .restart_r(restart_r));
  fbid_mst i_mst (.ref_clk(ref_clk), .diag_ident_r(diag_ident_r),
    .diag_valid_r(diag_valid_r), .cyclic_active(cyclic_active),
    .prm_frame_pulse(prm_frame_pulse), .addr_frame_pulse(addr_frame_pulse),
    .frame_ident(frame_ident), .frame_new_addr(frame_new_addr),
    .diag_req_pulse(diag_req_pulse));
  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  task chk(input string nm, input [31:0] g, input [31:0] e);
  begin
    check_count = check_count + 1;
    if (g !== e)
    begin
      err_count = err_count + 1;
      $display("mismatch %0s expected %h seen %h", nm, e, g);
    end
  end
  endtask
  // One idle cycle after each access keeps every strobe to one edit per step
  task acc(input w, input [4:0] a, input [31:0] d);
  begin
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    @(posedge ref_clk);
    while (avs_waitrequest !== 1'b0)
      @(posedge ref_clk);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge ref_clk);
  end
  endtask
  task sel_case(input [7:0] s, input [15:0] ei, input nd, input cd);
  begin
    acc(1'b1, `FBID_REG_SEL, {24'h00_0000, s});
    acc(1'b0, `FBID_REG_STAT, 32'h0000_0000);
    chk("ident", q[15:0], ei);
    acc(1'b0, `FBID_REG_DIAG, 32'h0000_0000);
    chk("blocks", q[21:16], 6'h13);
    chk("new_diag", new_diag_r, nd);
    chk("condensed", status_condensed_r, cd);
  end
  endtask
  task finish_test;
  begin
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  end
  endtask
  initial
  begin
    #50000;
    err_count = err_count + 1;
    finish_test;
  end
  initial
  begin
    err_count = 0;
    check_count = 0;
    nrst = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 5'h00;
    avs_writedata = 32'h0000_0000;
    user_cfg_condensed = 1'b0;
    cyc_access_req = 1'b0;
    cyc_module_idx = 2'h0;
    dip_pins = 8'h80;
    repeat (3) @(posedge ref_clk);
    nrst <= 1'b1;
    @(posedge ref_clk);
    acc(1'b0, `FBID_REG_SEL, 32'h0000_0000);
    chk("sel", q, 32'h0000_0000);
    acc(1'b0, `FBID_REG_ADDR, 32'h0000_0000);
    chk("soft addr", q, 32'h0000_007E);
    acc(1'b0, `FBID_REG_STAT, 32'h0000_0000);
    chk("stat", q, {5'h00, 7'h7E, 4'h1, PID});
    acc(1'b0, 5'h14, 32'h0000_0000);
    chk("unmapped", q, 32'h0000_0000);
    $display("test reset done");
    acc(1'b1, `FBID_REG_CTRL, 32'h0000_0001);
    sel_case(`FBID_SEL_PROFILE, PID, 1'b1, 1'b1);
    sel_case(`FBID_SEL_NEW, NID, 1'b1, 1'b1);
    sel_case(`FBID_SEL_LEGACY, LID, 1'b0, 1'b0);
    acc(1'b1, `FBID_REG_SEL, 32'h0000_0005);
    acc(1'b0, `FBID_REG_SEL, 32'h0000_0000);
    chk("sel bad", q, 32'h0000_0080);
    $display("test selector done");
    sel_case(`FBID_SEL_NEW, NID, 1'b1, 1'b1);
    acc(1'b1, `FBID_REG_CTRL, 32'h0000_0000);
    acc(1'b0, `FBID_REG_CTRL, 32'h0000_0000);
    chk("ctrl", q, 32'h0000_0000);
    chk("classic", status_condensed_r, 1'b0);
    user_cfg_condensed <= 1'b1;
    repeat (2) @(posedge ref_clk);
    chk("user cfg", status_condensed_r, 1'b1);
    i_mst.set_cyc(1'b1);
    acc(1'b1, `FBID_REG_SEL, 32'h0000_0000);
    acc(1'b0, `FBID_REG_SEL, 32'h0000_0000);
    chk("sel locked", q, 32'h0000_0001);
    cyc_access_req <= 1'b1;
    repeat (2) @(posedge ref_clk);
    chk("grant", cyc_access_grant_r, 1'b1);
    cyc_module_idx <= 2'h1;
    repeat (2) @(posedge ref_clk);
    chk("grant idx1", cyc_access_grant_r, 1'b0);
    cyc_access_req <= 1'b0;
    i_mst.set_cyc(1'b0);
    i_mst.set_cyc(1'b1);
    chk("resume", active_ident_r, NID);
    i_mst.set_cyc(1'b0);
    $display("test cyclic done");
    acc(1'b1, `FBID_REG_SEL, {24'h00_0000, `FBID_SEL_AUTO});
    chk("hunting", ident_defined_r, 1'b0);
    for (k = 0; k < 4; k = k + 1)
    begin
      i_mst.diag(id, v);
      chk("diag ident", id, ROT[63 - 16 * k -: 16]);
      chk("diag valid", v, 1'b1);
    end
    i_mst.frame(1'b1, 16'h1234, 7'h00);
    repeat (2) @(posedge ref_clk);
    chk("unknown id", ident_defined_r, 1'b0);
    i_mst.frame(1'b1, PID, 7'h00);
    repeat (2) @(posedge ref_clk);
    chk("adopted", active_ident_r, PID);
    chk("fixed", ident_defined_r, 1'b1);
    i_mst.diag(id, v);
    chk("fixed diag", id, PID);
    chk("fixed fmt", new_diag_r, 1'b1);
    $display("test adapt done");
    acc(1'b1, `FBID_REG_ADDR, 32'h0000_00C8);
    acc(1'b0, `FBID_REG_ADDR, 32'h0000_0000);
    chk("addr range", q, 32'h0000_007E);
    acc(1'b1, `FBID_REG_ADDR, 32'h0000_007D);
    chk("soft station", station_addr_r, 7'h7D);
    acc(1'b1, `FBID_REG_SEL, 32'h0000_0000);
    i_mst.frame(1'b0, LID, 7'h09);
    repeat (2) @(posedge ref_clk);
    chk("frame station", station_addr_r, 7'h09);
    chk("static id", active_ident_r, PID);
    dip_pins <= 8'h2A;
    n = 0;
    while (restart_r !== 1'b1 && n < 100)
    begin
      @(posedge ref_clk);
      n = n + 1;
    end
    chk("settle", n >= 20 && n <= 30, 1'b1);
    chk("hw station", station_addr_r, 7'h2A);
    $display("test address done");
    finish_test;
  end
endmodule
